/* File: tgcr_defs.svh */
// Purpose: offsets, field positions and reset values of the network client control bank
// Assumes: 32-bit Avalon-MM word bus, byte addresses
// Notes: included by the top module only; the package does not include it
`ifndef TGCR_DEFS_SVH
`define TGCR_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TGCR_OFS_CONTROL 8'h00
`define TGCR_OFS_STATUS 8'h04
`define TGCR_OFS_IPV4_ADDR 8'h10
`define TGCR_OFS_MCAST_ADDR 8'h14
`define TGCR_OFS_SUBNET_MASK 8'h18
`define TGCR_OFS_GATEWAY_ADDR 8'h1C

// ----------------------------------------
// control word fields
// ----------------------------------------
`define TGCR_BIT_CFG_CHANGE 1
`define TGCR_BIT_PHY_RESET 2
`define TGCR_TEST_LSB 3
`define TGCR_TEST_MSB 4
`define TGCR_BIT_POWER_DOWN 5
`define TGCR_MEDIA_LSB 6
`define TGCR_MEDIA_MSB 8
`define TGCR_BIT_SIGNAL_DETECT 9
`define TGCR_BIT_TX_FAULT 10
`define TGCR_BIT_MODSEL_N 11
`define TGCR_BIT_MODRST_N 12
`define TGCR_BIT_LOW_POWER 13
`define TGCR_BIT_MAC_HOLD 14
`define TGCR_BIT_STACK_HOLD 15
`define TGCR_BIT_AUTO_ADDR 16
`define TGCR_BIT_LINK_LIGHT 17
`define TGCR_CONTROL_MASK 32'h0003FFFE

// ----------------------------------------
// status word fields
// ----------------------------------------
`define TGCR_BIT_IRQ_N 0
`define TGCR_BIT_PRESENT_N 2
`define TGCR_BIT_CTS0 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define TGCR_RESET_WORD 32'h00000000
`define TGCR_RESET_TEST 2'h0

`endif

/* File: tgcr_pkg.sv */
// Purpose: shared types of the network client control bank
// Assumes: nothing beyond the defs header
// Notes: constants live in tgcr_defs.svh
package tgcr_pkg;
  typedef enum logic [1:0] {
    TGCR_TEST_NORMAL,
    TGCR_TEST_LOCAL_LOOP,
    TGCR_TEST_REMOTE_LOOP,
    TGCR_TEST_SPARE
  } tgcr_test_mode_t;
  typedef enum logic {
    TGCR_BUS_IDLE,
    TGCR_BUS_DONE
  } tgcr_bus_state_t;
endpackage

/* File: tgcr_ctrl_regs.sv */
// Purpose: control and status register bank of the 10G TCP/IP client
// Assumes: Avalon-MM slave with waitrequest, one clock, inputs synchronous
// Notes: every access takes one wait cycle, answered on the second edge
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tgcr_defs.svh"

// Function
// - phy held in reset while bit set
// - phy powered off while power-down set
// - module-select line driven from bit
// - active-low module reset driven from bit
// - low-power line driven from bit
// - mac held in reset while bit set
// - stack held in reset while bit set
// - address-mode line driven from bit; the fixed words go out whatever its value
// - link light follows its bit
// - status shows raw interrupt line
// - status shows raw module-present line
// - status shows socket zero clear to send
// - fixed ipv4 address word at 0x10
// - multicast address word at 0x14, reset zero
module tgcr_ctrl_regs
  import tgcr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic PHY_RESET,
  output logic PHY_POWER_DOWN,
  output tgcr_pkg::tgcr_test_mode_t PHY_TEST_MODE,
  output logic [2:0] OPTIC_MEDIA_TYPE,
  output logic PHY_SIGNAL_DETECT,
  output logic PHY_TX_FAULT,
  output logic OPTIC_MODULE_SELECT_N,
  output logic OPTIC_MODULE_RESET_N,
  output logic OPTIC_LOW_POWER,
  output logic MAC_LAYER_HOLD,
  output logic STACK_HOLD,
  output logic AUTO_ADDRESS_SELECT,
  output logic OPTIC_LINK_LIGHT,
  output logic [31:0] STATIC_IPV4_ADDRESS,
  output logic [31:0] IPV4_MULTICAST_ADDRESS,
  output logic [31:0] IPV4_SUBNET_MASK,
  output logic [31:0] IPV4_GATEWAY_ADDRESS,
  input wire logic OPTIC_IRQ_N,
  input wire logic OPTIC_PRESENT_N,
  input wire logic SOCKET_ZERO_CLEAR_TO_SEND
);
  import tgcr_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  tgcr_bus_state_t bus_q;
  logic req;
  logic acc;
  logic wr_acc;
  logic [31:0] be_mask;
  assign req = AVS_READ | AVS_WRITE;
  // one wait cycle keeps read data registered and the decode off the critical path
  assign AVS_WAITREQUEST = ~(bus_q == TGCR_BUS_DONE);
  assign acc = req & (bus_q == TGCR_BUS_DONE);
  assign wr_acc = acc & AVS_WRITE;
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_q <= TGCR_BUS_IDLE;
    end else begin
      case (bus_q)
        TGCR_BUS_IDLE: begin
          if (req) begin
            bus_q <= TGCR_BUS_DONE;
          end
        end
        TGCR_BUS_DONE: begin
          bus_q <= TGCR_BUS_IDLE;
        end
        default: begin
          bus_q <= TGCR_BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wr_control;
  logic wr_ipv4;
  logic wr_mcast;
  logic wr_subnet;
  logic wr_gateway;
  // unmapped offsets match no strobe, so their writes fall away
  assign wr_control = wr_acc && (AVS_ADDRESS == `TGCR_OFS_CONTROL);
  assign wr_ipv4 = wr_acc && (AVS_ADDRESS == `TGCR_OFS_IPV4_ADDR);
  assign wr_mcast = wr_acc && (AVS_ADDRESS == `TGCR_OFS_MCAST_ADDR);
  assign wr_subnet = wr_acc && (AVS_ADDRESS == `TGCR_OFS_SUBNET_MASK);
  assign wr_gateway = wr_acc && (AVS_ADDRESS == `TGCR_OFS_GATEWAY_ADDR);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [31:0] control_q;
  logic [31:0] ipv4_q;
  logic [31:0] mcast_q;
  logic [31:0] subnet_q;
  logic [31:0] gateway_q;
  logic [31:0] control_d;
  logic [31:0] ipv4_d;
  logic [31:0] mcast_d;
  logic [31:0] subnet_d;
  logic [31:0] gateway_d;
  logic [1:0] test_q;

  // byte lanes that are not enabled keep their old contents
  assign control_d = ((control_q & ~be_mask) | (AVS_WRITEDATA & be_mask))
                     & `TGCR_CONTROL_MASK;
  assign ipv4_d = (ipv4_q & ~be_mask) | (AVS_WRITEDATA & be_mask);
  assign mcast_d = (mcast_q & ~be_mask) | (AVS_WRITEDATA & be_mask);
  assign subnet_d = (subnet_q & ~be_mask) | (AVS_WRITEDATA & be_mask);
  assign gateway_d = (gateway_q & ~be_mask) | (AVS_WRITEDATA & be_mask);

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      control_q <= `TGCR_RESET_WORD;
    end else if (wr_control) begin
      control_q <= control_d;
    end
  end

  // the phy sees a new test mode only while software holds the change bit set
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      test_q <= `TGCR_RESET_TEST;
    end else if (control_q[`TGCR_BIT_CFG_CHANGE]) begin
      test_q <= control_q[`TGCR_TEST_MSB:`TGCR_TEST_LSB];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ipv4_q <= `TGCR_RESET_WORD;
    end else if (wr_ipv4) begin
      ipv4_q <= ipv4_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mcast_q <= `TGCR_RESET_WORD;
    end else if (wr_mcast) begin
      mcast_q <= mcast_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      subnet_q <= `TGCR_RESET_WORD;
    end else if (wr_subnet) begin
      subnet_q <= subnet_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gateway_q <= `TGCR_RESET_WORD;
    end else if (wr_gateway) begin
      gateway_q <= gateway_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_d;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`TGCR_BIT_IRQ_N] = OPTIC_IRQ_N;
    status_word[`TGCR_BIT_PRESENT_N] = OPTIC_PRESENT_N;
    status_word[`TGCR_BIT_CTS0] = SOCKET_ZERO_CLEAR_TO_SEND;
  end

  always_comb begin
    rd_d = 32'h00000000;
    case (AVS_ADDRESS)
      `TGCR_OFS_CONTROL: rd_d = control_q;
      `TGCR_OFS_STATUS: rd_d = status_word;
      `TGCR_OFS_IPV4_ADDR: rd_d = ipv4_q;
      `TGCR_OFS_MCAST_ADDR: rd_d = mcast_q;
      `TGCR_OFS_SUBNET_MASK: rd_d = subnet_q;
      `TGCR_OFS_GATEWAY_ADDR: rd_d = gateway_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  logic rd_capture;
  assign rd_capture = AVS_READ && (bus_q == TGCR_BUS_IDLE);
  // data is captured during the wait cycle, so it stands at the accepting edge
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      AVS_READDATA <= 32'h00000000;
    end else if (rd_capture) begin
      AVS_READDATA <= rd_d;
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  // every line is registered so the far side never sees a decode glitch
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PHY_RESET <= 1'b0;
      PHY_POWER_DOWN <= 1'b0;
    end else begin
      PHY_RESET <= control_q[`TGCR_BIT_PHY_RESET];
      PHY_POWER_DOWN <= control_q[`TGCR_BIT_POWER_DOWN];
    end
  end

  // test mode trails the other lines by one clock, through the change latch
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PHY_TEST_MODE <= TGCR_TEST_NORMAL;
      OPTIC_MEDIA_TYPE <= 3'h0;
    end else begin
      PHY_TEST_MODE <= tgcr_test_mode_t'(test_q);
      OPTIC_MEDIA_TYPE <= control_q[`TGCR_MEDIA_MSB:`TGCR_MEDIA_LSB];
    end
  end

  // software mirrors the module's own signals here until hardware takes over
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PHY_SIGNAL_DETECT <= 1'b0;
      PHY_TX_FAULT <= 1'b0;
    end else begin
      PHY_SIGNAL_DETECT <= control_q[`TGCR_BIT_SIGNAL_DETECT];
      PHY_TX_FAULT <= control_q[`TGCR_BIT_TX_FAULT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      OPTIC_MODULE_SELECT_N <= 1'b0;
      OPTIC_MODULE_RESET_N <= 1'b0;
      OPTIC_LOW_POWER <= 1'b0;
      OPTIC_LINK_LIGHT <= 1'b0;
    end else begin
      OPTIC_MODULE_SELECT_N <= control_q[`TGCR_BIT_MODSEL_N];
      OPTIC_MODULE_RESET_N <= control_q[`TGCR_BIT_MODRST_N];
      OPTIC_LOW_POWER <= control_q[`TGCR_BIT_LOW_POWER];
      OPTIC_LINK_LIGHT <= control_q[`TGCR_BIT_LINK_LIGHT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      MAC_LAYER_HOLD <= 1'b0;
      STACK_HOLD <= 1'b0;
      AUTO_ADDRESS_SELECT <= 1'b0;
    end else begin
      MAC_LAYER_HOLD <= control_q[`TGCR_BIT_MAC_HOLD];
      STACK_HOLD <= control_q[`TGCR_BIT_STACK_HOLD];
      AUTO_ADDRESS_SELECT <= control_q[`TGCR_BIT_AUTO_ADDR];
    end
  end

  // address the stack uses: fixed registers driven straight out, whatever the dhcp bit says
  assign STATIC_IPV4_ADDRESS = ipv4_q;
  assign IPV4_MULTICAST_ADDRESS = mcast_q;
  assign IPV4_SUBNET_MASK = subnet_q;
  assign IPV4_GATEWAY_ADDRESS = gateway_q;
endmodule
`default_nettype wire

/* File: tgcr_ctrl_regs_assertions.sv */
// Purpose: port checks of the network client control bank
// Assumes: full byte enables on the watched writes
// Notes: bound to tgcr_ctrl_regs at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module tgcr_ctrl_regs_assertions (
  input wire logic SYS_CLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA, AVS_READDATA, STATIC_IPV4_ADDRESS,
  input wire logic [31:0] IPV4_MULTICAST_ADDRESS,
  input wire logic PHY_RESET, PHY_POWER_DOWN, OPTIC_MODULE_SELECT_N, OPTIC_MODULE_RESET_N,
  input wire logic OPTIC_LOW_POWER, MAC_LAYER_HOLD, STACK_HOLD, OPTIC_LINK_LIGHT,
  input wire logic [2:0] OPTIC_MEDIA_TYPE,
  input wire tgcr_pkg::tgcr_test_mode_t PHY_TEST_MODE,
  input wire logic PHY_SIGNAL_DETECT, PHY_TX_FAULT, AUTO_ADDRESS_SELECT,
  input wire logic OPTIC_IRQ_N, OPTIC_PRESENT_N, SOCKET_ZERO_CLEAR_TO_SEND
);
  import tgcr_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  logic acc, cw;
  assign acc = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign cw = acc && AVS_WRITE && AVS_ADDRESS == 8'h00 && AVS_BYTEENABLE == 4'hF;
  AST_ONE_WAIT: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("access not answered in one wait");
  AST_PHY_RESET: assert property (cw |-> ##2 PHY_RESET == $past(AVS_WRITEDATA[2], 2))
    else $error("phy reset does not follow its bit");
  AST_TEST_MODE: assert property (cw && AVS_WRITEDATA[1] |-> ##3
    PHY_TEST_MODE == $past(AVS_WRITEDATA[4:3], 3)) else $error("test mode not applied");
  AST_TEST_HOLD: assert property (cw && !AVS_WRITEDATA[1] |=> $stable(PHY_TEST_MODE) [*3])
    else $error("test mode changed without pulse");
  AST_OPTIC: assert property (cw |-> ##2
    {OPTIC_LINK_LIGHT, OPTIC_LOW_POWER, OPTIC_MODULE_RESET_N, OPTIC_MODULE_SELECT_N} ==
    {$past(AVS_WRITEDATA[17], 2), $past(AVS_WRITEDATA[13:11], 2)}) else $error("optic lines");
  AST_HOLDS: assert property (cw |-> ##2
    {STACK_HOLD, MAC_LAYER_HOLD, PHY_POWER_DOWN, OPTIC_MEDIA_TYPE} ==
    {$past(AVS_WRITEDATA[15:14], 2), $past(AVS_WRITEDATA[5], 2), $past(AVS_WRITEDATA[8:6], 2)})
    else $error("hold, power or media lines wrong");
  AST_PASS_LINES: assert property (cw |-> ##2
    {AUTO_ADDRESS_SELECT, PHY_TX_FAULT, PHY_SIGNAL_DETECT} ==
    {$past(AVS_WRITEDATA[16], 2), $past(AVS_WRITEDATA[10:9], 2)})
    else $error("pass-through lines wrong");
  AST_STATUS: assert property (acc && AVS_READ && AVS_ADDRESS == 8'h04 |->
    AVS_READDATA == {28'h0, $past(SOCKET_ZERO_CLEAR_TO_SEND), $past(OPTIC_PRESENT_N), 1'b0,
    $past(OPTIC_IRQ_N)}) else $error("status word wrong");
  AST_STATIC: assert property (acc && AVS_WRITE && AVS_ADDRESS == 8'h10 &&
    AVS_BYTEENABLE == 4'hF |=> STATIC_IPV4_ADDRESS == $past(AVS_WRITEDATA))
    else $error("static address not stored");
  AST_MCAST: assert property (acc && AVS_WRITE && AVS_ADDRESS == 8'h14 &&
    AVS_BYTEENABLE == 4'hF |=> IPV4_MULTICAST_ADDRESS == $past(AVS_WRITEDATA))
    else $error("multicast address not stored");
  AST_UNMAPPED: assert property (acc && AVS_READ && AVS_ADDRESS inside {8'h08, 8'h0C} |->
    AVS_READDATA == 32'h0) else $error("unmapped read not zero");
endmodule
bind tgcr_ctrl_regs tgcr_ctrl_regs_assertions u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .STATIC_IPV4_ADDRESS(STATIC_IPV4_ADDRESS),
  .IPV4_MULTICAST_ADDRESS(IPV4_MULTICAST_ADDRESS), .PHY_RESET(PHY_RESET),
  .PHY_POWER_DOWN(PHY_POWER_DOWN), .OPTIC_MODULE_SELECT_N(OPTIC_MODULE_SELECT_N),
  .OPTIC_MODULE_RESET_N(OPTIC_MODULE_RESET_N), .OPTIC_LOW_POWER(OPTIC_LOW_POWER),
  .MAC_LAYER_HOLD(MAC_LAYER_HOLD), .STACK_HOLD(STACK_HOLD), .OPTIC_LINK_LIGHT(OPTIC_LINK_LIGHT),
  .OPTIC_MEDIA_TYPE(OPTIC_MEDIA_TYPE), .PHY_TEST_MODE(PHY_TEST_MODE), .OPTIC_IRQ_N(OPTIC_IRQ_N),
  .PHY_SIGNAL_DETECT(PHY_SIGNAL_DETECT), .PHY_TX_FAULT(PHY_TX_FAULT),
  .AUTO_ADDRESS_SELECT(AUTO_ADDRESS_SELECT),
  .OPTIC_PRESENT_N(OPTIC_PRESENT_N), .SOCKET_ZERO_CLEAR_TO_SEND(SOCKET_ZERO_CLEAR_TO_SEND));
`default_nettype wire

/* File: tgcr_optic_model.sv */
// Purpose: behavioural optical transceiver on the sideband lines
// Assumes: levels only, no management bus traffic
// Notes: alarm shows only while the module is present and running
`timescale 1ns/10ps
`default_nettype none
module tgcr_optic_model (
  input wire logic installed,
  input wire logic alarm,
  input wire logic module_reset_n,
  output logic irq_n,
  output logic present_n
);
  // a module held in reset cannot raise its interrupt
  assign irq_n = !(alarm && installed && module_reset_n);
  assign present_n = !installed;
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench of the control bank
// Assumes: full byte enables except one lane-masked write
// Notes: table rows first, then field walks, status and a second reset
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tgcr_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, inst = 1'b0, alarm = 1'b0;
  logic cts = 1'b0, wreq, prst, pdn, sd, txf, msel_n, mrst_n, lp, mach, stkh, auto, link;
  logic irq_n, pres_n;
  logic [7:0] adr = 8'h00;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0, rdat, ip, mc, sm, gw, q, d;
  logic [2:0] media;
  tgcr_test_mode_t tm;
  int fails = 0, total_checks = 0;
  logic [71:0] rows [7] = '{{8'h00, 32'hFFFFFFFF, 32'h0003FFFE},
    {8'h10, 32'hC0A80A07, 32'hC0A80A07}, {8'h14, 32'hEF0000FB, 32'hEF0000FB},
    {8'h18, 32'hFFFFFF00, 32'hFFFFFF00}, {8'h1C, 32'hC0A80A01, 32'hC0A80A01},
    {8'h0C, 32'h5A5AA5A5, 32'h0}, {8'h04, 32'hFFFFFFFF, 32'h00000005}};
  always #5 clk = ~clk;
  tgcr_ctrl_regs dut (.SYS_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .PHY_RESET(prst), .PHY_POWER_DOWN(pdn), .PHY_TEST_MODE(tm),
    .OPTIC_MEDIA_TYPE(media), .PHY_SIGNAL_DETECT(sd), .PHY_TX_FAULT(txf),
    .OPTIC_MODULE_SELECT_N(msel_n), .OPTIC_MODULE_RESET_N(mrst_n), .OPTIC_LOW_POWER(lp),
    .MAC_LAYER_HOLD(mach), .STACK_HOLD(stkh), .AUTO_ADDRESS_SELECT(auto),
    .OPTIC_LINK_LIGHT(link), .STATIC_IPV4_ADDRESS(ip), .IPV4_MULTICAST_ADDRESS(mc),
    .IPV4_SUBNET_MASK(sm), .IPV4_GATEWAY_ADDRESS(gw), .OPTIC_IRQ_N(irq_n),
    .OPTIC_PRESENT_N(pres_n), .SOCKET_ZERO_CLEAR_TO_SEND(cts));
  tgcr_optic_model u_optic (.installed(inst), .alarm(alarm), .module_reset_n(mrst_n),
    .irq_n(irq_n), .present_n(pres_n));
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is sampled low; an edge passes before the next one
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) fails++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] outs();
    return {16'h0, media, tm, link, auto, stkh, mach, lp, mrst_n, msel_n, txf, sd, pdn, prst};
  endfunction
  function automatic logic [31:0] ctl_exp(input logic [31:0] v);
    return {16'h0, v[8:6], v[4:3], v[17:9], v[5], v[2]};
  endfunction
  task automatic wctl(input logic [31:0] v);
    bus(1'b1, 8'h00, v);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(outs(), 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rows[i][71:64], 32'h0);
      chk(q, 32'h0);
    end
    foreach (rows[i]) begin
      bus(1'b1, rows[i][71:64], rows[i][63:32]);
      bus(1'b0, rows[i][71:64], 32'h0);
      chk(q, rows[i][31:0]);
    end
    chk(ip, rows[1][31:0]);
    chk(mc, rows[2][31:0]);
    chk(sm, rows[3][31:0]);
    chk(gw, rows[4][31:0]);
    be <= 4'h3;
    bus(1'b1, 8'h14, 32'h12345678);
    be <= 4'hF;
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'hEF005678);
    for (int b = 2; b < 18; b++) begin
      d = 32'h2 | (32'h1 << b);
      wctl(d);
      chk(outs(), ctl_exp(d));
    end
    for (int i = 0; i < 3; i++) begin
      d = ((32'h7 - i) << 6) | (i << 3) | 32'h2;
      wctl(d);
      chk(outs(), ctl_exp(d));
    end
    wctl(32'h00000008);
    chk({30'h0, tm}, 32'h2);
    wctl(32'h0000000A);
    chk({30'h0, tm}, 32'h1);
    wctl(32'h00001000);
    for (int j = 0; j < 8; j++) begin
      inst <= j[0];
      alarm <= j[1];
      cts <= j[2];
      @(posedge clk);
      bus(1'b0, 8'h04, 32'h0);
      chk(q, {28'h0, j[2], !j[0], 1'b0, !(j[0] && j[1])});
    end
    wctl(32'h00000000);
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'h00000009);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(outs(), 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
